//--- inc/tpio_pkg.sv
// Package for the two-port I/O block: register map, field positions, carriers.
// Overview of operation
// [RULE1] A one in the global pull-up disable bit switches off every port pull-up whatever direction and output hold.
// [RULE2] The force-high enable bit changes only through the timed unlock sequence; other writes leave it alone.
// [RULE3] Software opens the unlock window by writing only the change-enable bit as one to the override register.
// [RULE4] Within four cycles software writes change-enable zero with the new force-high value, applied only in that window.
// [RULE5] Reserved bits of the override register always read zero.
// [RULE6] With the transmit drive override at zero the transmit pin is driven high or low by the transmit value alone.
// [RULE7] With the override at one a high transmit value tristates or pulls up per the output bit; low drives low.
// [RULE8] While the serial-bus module is disabled the transmit drive override has no effect on the pin.
// [RULE9] While force-high is set port B pin zero is driven high whatever its port registers hold.
// [RULE10] Clearing force-high returns port B pin zero to normal port control.
// [RULE11] The transmit drive override steers transmit drive whenever the serial-bus module owns the pin.
// [RULE12] Direction one drives the output bit; direction zero is an input pulled up when the output bit is one.
// [RULE13] Pin-level registers read the synchronised pin levels, not the stored output bits.
package tpio_pkg;
  // ==========================================================
  // Register offsets (word index; byte address is four times)
  localparam logic [7:0] OFS_PA_PIN   = 8'h00;
  localparam logic [7:0] OFS_PA_DIR   = 8'h01;
  localparam logic [7:0] OFS_PA_OUT   = 8'h02;
  localparam logic [7:0] OFS_PB_PIN   = 8'h03;
  localparam logic [7:0] OFS_PB_DIR   = 8'h04;
  localparam logic [7:0] OFS_PB_OUT   = 8'h05;
  localparam logic [7:0] OFS_CORE_CTL = 8'h35;
  localparam logic [7:0] OFS_PB_OVR   = 8'hdc;
  // ==========================================================
  // Field positions and masks
  localparam int         BIT_PULLUP_OFF = 4;
  localparam int         BIT_CHG_EN     = 7;
  localparam int         BIT_TX_OVR     = 3;
  localparam int         BIT_FORCE_HI   = 0;
  localparam int         BIT_CLK_OUT    = 5;
  localparam int         BIT_VEC_SEL    = 1;
  localparam int         TX_PIN         = 3;
  localparam logic [7:0] CORE_CTL_MASK  = 8'h33;
  localparam logic [7:0] PB_OVR_MASK    = 8'h89;
  localparam logic [7:0] UNLOCK_VALUE   = 8'h80;
  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam logic [2:0] UNLOCK_CYCLES  = 3'h4;
  localparam int         PA_WIDTH       = 2;
  localparam int         PB_WIDTH       = 8;
  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [PB_WIDTH-1:0] o;
    logic [PB_WIDTH-1:0] oe;
    logic [PB_WIDTH-1:0] pu;
  } tpio_pins_t;
  typedef enum logic [1:0] {TPIO_IDLE, TPIO_OPEN} tpio_lock_t;
endpackage

//--- logic/tpio_top.sv
// Two-port I/O block with Wishbone registers and port B override.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module tpio_top (
  input  wire logic                   clk,       // 25 MHz clock
  input  wire logic                   rst,       // Synchronous reset, high
  input  wire logic                   ce,        // Clock enable
  input  wire logic                   cyc_i,     // Wishbone cycle
  input  wire logic                   stb_i,     // Wishbone strobe
  input  wire logic                   we_i,      // Wishbone write
  input  wire logic [9:0]             adr_i,     // Byte address
  input  wire logic [3:0]             sel_i,     // Byte lanes
  input  wire logic [31:0]            dat_i,     // Write data
  output logic      [31:0]            dat_o,     // Read data
  output logic                        ack_o,     // Acknowledge
  output logic                        err_o,     // Unmapped address
  input  wire logic [1:0]             pa_i,      // Port A pin levels
  output tpio_pkg::tpio_pins_t        pa_pins,   // Port A drive (low bits used)
  input  wire logic [7:0]             pb_i,      // Port B pin levels
  output tpio_pkg::tpio_pins_t        pb_pins,   // Port B drive
  input  wire logic                   sb_tx_en,  // Serial bus owns transmit pin
  input  wire logic                   serial_bus_transmit, // Transmit value
  output logic                        clock_out_enable,    // Control bit
  output logic                        vector_table_select  // Control bit
);
  import tpio_pkg::*;

  // ==========================================================
  // Registers
  logic [1:0]  port_a_direction;
  logic [1:0]  port_a_output;
  logic [7:0]  port_b_direction;
  logic [7:0]  port_b_output;
  logic [7:0]  core_control;
  logic        tx_drive_override;
  logic        force_high_enable;
  logic        override_change_enable;
  logic [2:0]  unlock_cnt;
  tpio_lock_t  lock_state;
  logic [1:0]  pa_s1, pa_s2;
  logic [7:0]  pb_s1, pb_s2;

  // ==========================================================
  // Bus decode
  // A pending ack blocks a second take while the master still holds stb
  wire         req       = cyc_i & stb_i & ~ack_o & ~err_o & ce;
  wire [7:0]   idx       = adr_i[9:2];
  wire         lane0     = sel_i[0];
  wire         wr        = req & we_i & lane0;
  wire         hit_pa_p  = idx == OFS_PA_PIN;
  wire         hit_pa_d  = idx == OFS_PA_DIR;
  wire         hit_pa_o  = idx == OFS_PA_OUT;
  wire         hit_pb_p  = idx == OFS_PB_PIN;
  wire         hit_pb_d  = idx == OFS_PB_DIR;
  wire         hit_pb_o  = idx == OFS_PB_OUT;
  wire         hit_cc    = idx == OFS_CORE_CTL;
  wire         hit_ov    = idx == OFS_PB_OVR;
  wire         mapped    = hit_pa_p | hit_pa_d | hit_pa_o | hit_pb_p | hit_pb_d | hit_pb_o | hit_cc | hit_ov;
  wire [7:0]   wbyte     = dat_i[7:0];
  wire         ov_wr     = wr & hit_ov;
  wire         unlock_wr = ov_wr & (wbyte == UNLOCK_VALUE);                        // [RULE3]
  wire         window    = lock_state == TPIO_OPEN;
  wire         commit_wr = ov_wr & window & ~wbyte[BIT_CHG_EN];                    // [RULE4]
  wire         pullup_off = core_control[BIT_PULLUP_OFF];
  wire [7:0]   ovr_read  = {override_change_enable, 3'h0, tx_drive_override, 2'h0,
                            force_high_enable};                                    // [RULE5]
  wire [7:0]   rd_byte   = hit_pa_p ? {6'h0, pa_s2} :                              // [RULE13]
                           hit_pa_d ? {6'h0, port_a_direction} :
                           hit_pa_o ? {6'h0, port_a_output} :
                           hit_pb_p ? pb_s2 :                                      // [RULE13]
                           hit_pb_d ? port_b_direction :
                           hit_pb_o ? port_b_output :
                           hit_cc   ? core_control :
                           hit_ov   ? ovr_read : RESET_VALUE;

  // ==========================================================
  // Pin drive: normal port function per bit
  logic [7:0] nb_o, nb_oe, nb_pu, fb_o, fb_oe, fb_pu;
  logic [1:0] na_o, na_oe, na_pu;
  genvar g;
  generate
    for (g = 0; g < PB_WIDTH; g++) begin : g_pb
      always_comb begin
        nb_o[g]  = port_b_output[g];
        nb_oe[g] = port_b_direction[g];                                            // [RULE12]
        nb_pu[g] = ~port_b_direction[g] & port_b_output[g] & ~pullup_off;          // [RULE1] [RULE12]
      end
    end
    for (g = 0; g < PA_WIDTH; g++) begin : g_pa
      always_comb begin
        na_o[g]  = port_a_output[g];
        na_oe[g] = port_a_direction[g];                                            // [RULE12]
        na_pu[g] = ~port_a_direction[g] & port_a_output[g] & ~pullup_off;          // [RULE1] [RULE12]
      end
    end
  endgenerate

  // Overrides on transmit pin and pin zero
  // Force-high is applied last so it wins on pin zero over everything
  always_comb begin
    fb_o  = nb_o;
    fb_oe = nb_oe;
    fb_pu = nb_pu;
    if (sb_tx_en) begin                                                            // [RULE8] [RULE11]
      if (!tx_drive_override || !serial_bus_transmit) begin
        fb_o[TX_PIN]  = serial_bus_transmit;                                       // [RULE6] [RULE7]
        fb_oe[TX_PIN] = 1'b1;
        fb_pu[TX_PIN] = 1'b0;
      end else begin
        fb_o[TX_PIN]  = 1'b0;
        fb_oe[TX_PIN] = 1'b0;                                                      // [RULE7]
        fb_pu[TX_PIN] = port_b_output[TX_PIN] & ~pullup_off;                      // [RULE7] [RULE1]
      end
    end
    if (force_high_enable) begin                                                   // [RULE9] [RULE10]
      fb_o[0]  = 1'b1;
      fb_oe[0] = 1'b1;
      fb_pu[0] = 1'b0;
    end
  end

  // ==========================================================
  // Sequential state
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_direction       <= 2'h0;
      port_a_output          <= 2'h0;
      port_b_direction       <= RESET_VALUE;
      port_b_output          <= RESET_VALUE;
      core_control           <= RESET_VALUE;
      tx_drive_override      <= 1'b0;
      force_high_enable      <= 1'b0;
      override_change_enable <= 1'b0;
      lock_state             <= TPIO_IDLE;
      unlock_cnt             <= 3'h0;
      ack_o                  <= 1'b0;
      err_o                  <= 1'b0;
      dat_o                  <= 32'h0;
      pa_s1                  <= 2'h0;
      pa_s2                  <= 2'h0;
      pb_s1                  <= 8'h0;
      pb_s2                  <= 8'h0;
      pa_pins                <= '0;
      pb_pins                <= '0;
    end else if (ce) begin
      pa_s1   <= pa_i;
      pa_s2   <= pa_s1;
      pb_s1   <= pb_i;
      pb_s2   <= pb_s1;
      ack_o   <= req & mapped;
      err_o   <= req & ~mapped;
      dat_o   <= (req & mapped & ~we_i) ? {24'h0, rd_byte} : 32'h0;
      pa_pins <= '{o: {6'h0, na_o}, oe: {6'h0, na_oe}, pu: {6'h0, na_pu}};
      pb_pins <= '{o: fb_o, oe: fb_oe, pu: fb_pu};
      if (wr & hit_pa_d) port_a_direction <= wbyte[1:0];
      if (wr & hit_pa_o) port_a_output <= wbyte[1:0];
      if (wr & hit_pb_d) port_b_direction <= wbyte;
      if (wr & hit_pb_o) port_b_output <= wbyte;
      if (wr & hit_cc)   core_control <= wbyte & CORE_CTL_MASK;
      if (ov_wr) begin
        // Only the exact unlock value raises change-enable; stray writes keep it low
        tx_drive_override      <= wbyte[BIT_TX_OVR];
        override_change_enable <= unlock_wr;                                       // [RULE3]
      end
      if (commit_wr) force_high_enable <= wbyte[BIT_FORCE_HI];                   // [RULE2] [RULE4]
      case (lock_state)
        TPIO_IDLE: begin
          if (unlock_wr) begin
            lock_state <= TPIO_OPEN;
            unlock_cnt <= UNLOCK_CYCLES;
          end
        end
        TPIO_OPEN: begin
          // Any other override write ends the window; a fresh unlock restarts its count
          if (unlock_wr) begin
            unlock_cnt <= UNLOCK_CYCLES;
          end else if (ov_wr || unlock_cnt == 3'h1) begin                         // [RULE4]
            lock_state             <= TPIO_IDLE;
            unlock_cnt             <= 3'h0;
            override_change_enable <= 1'b0;
          end else begin
            unlock_cnt <= unlock_cnt - 3'h1;
          end
        end
        default: lock_state <= TPIO_IDLE;
      endcase
    end
  end

  assign clock_out_enable    = core_control[BIT_CLK_OUT];
  assign vector_table_select = core_control[BIT_VEC_SEL];

  // ==========================================================
  // Checks
  force_locked_a: assert property (@(posedge clk) disable iff (rst)          // [RULE2]
    (ce && !$past(commit_wr) && $past(ce && !rst)) |-> $stable(force_high_enable))
    else $error("force-high changed outside unlock window");
  window_len_a: assert property (@(posedge clk) disable iff (rst)            // [RULE4]
    (ce && unlock_wr && lock_state == TPIO_IDLE) |=> (lock_state == TPIO_OPEN && unlock_cnt == UNLOCK_CYCLES))
    else $error("unlock window not opened for four cycles");
  reserved_zero_a: assert property (@(posedge clk) disable iff (rst)         // [RULE5]
    (ack_o && $past(req && hit_ov && !we_i)) |-> (dat_o[6:4] == 3'h0 && dat_o[2:1] == 2'h0))
    else $error("reserved override bits read nonzero");
  pullup_off_a: assert property (@(posedge clk) disable iff (rst)            // [RULE1]
    ($past(ce && !rst) && $past(pullup_off)) |-> (pb_pins.pu == 8'h0 && pa_pins.pu == 8'h0))
    else $error("pull-up active while disabled");
  force_pin_a: assert property (@(posedge clk) disable iff (rst)             // [RULE9]
    ($past(ce && !rst) && $past(force_high_enable)) |-> (pb_pins.o[0] && pb_pins.oe[0]))
    else $error("pin zero not forced high");
  tx_normal_a: assert property (@(posedge clk) disable iff (rst)             // [RULE6]
    ($past(ce && !rst) && $past(sb_tx_en) && !$past(tx_drive_override))
      |-> (pb_pins.oe[3] && pb_pins.o[3] == $past(serial_bus_transmit)))
    else $error("transmit pin not actively driven");
  tx_open_a: assert property (@(posedge clk) disable iff (rst)               // [RULE7]
    ($past(ce && !rst) && $past(sb_tx_en) && $past(tx_drive_override) && $past(serial_bus_transmit))
      |-> !pb_pins.oe[3])
    else $error("transmit high still driven under override");
  tx_idle_a: assert property (@(posedge clk) disable iff (rst)               // [RULE8]
    ($past(ce && !rst) && !$past(sb_tx_en)) |-> pb_pins.oe[3] == $past(port_b_direction[3]))
    else $error("override affects pin with serial bus off");
  pin_read_a: assert property (@(posedge clk) disable iff (rst)              // [RULE13]
    (ack_o && $past(req && hit_pb_p && !we_i)) |-> dat_o[7:0] == $past(pb_s2))
    else $error("pin level read wrong");

  // ==========================================================
  // Checks: bus, registers and unlock window
  ack_pulse_a: assert property (@(posedge clk) disable iff (rst)
    ce && ack_o
    |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  ack_mapped_a: assert property (@(posedge clk) disable iff (rst)
    req && mapped
    |=> ack_o && !err_o)
    else $error("mapped access not acknowledged");
  err_unmapped_a: assert property (@(posedge clk) disable iff (rst)
    req && !mapped
    |=> err_o && !ack_o && dat_o == 32'h0)
    else $error("unmapped access not refused");
  idle_quiet_a: assert property (@(posedge clk) disable iff (rst)
    ce && !req
    |=> !ack_o && !err_o && dat_o == 32'h0)
    else $error("bus answer without request");
  dat_upper_a: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |-> dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  lane_guard_a: assert property (@(posedge clk) disable iff (rst)
    ce && cyc_i && stb_i && we_i && !lane0
    |=> $stable(port_b_output) && $stable(port_b_direction) && $stable(core_control))
    else $error("write without lane zero took effect");
  core_mask_a: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |-> (core_control & ~CORE_CTL_MASK) == 8'h00)
    else $error("read-only control bit set");
  core_write_a: assert property (@(posedge clk) disable iff (rst)  // [RULE1]
    wr && hit_cc
    |=> core_control == ($past(wbyte) & CORE_CTL_MASK))
    else $error("control write lost");
  pa_dir_write_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    wr && hit_pa_d
    |=> port_a_direction == $past(wbyte[1:0]))
    else $error("port A direction write lost");
  pb_out_write_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    wr && hit_pb_o
    |=> port_b_output == $past(wbyte))
    else $error("port B output write lost");
  window_state_a: assert property (@(posedge clk) disable iff (rst)  // [RULE3]
    1'b1
    |-> override_change_enable == (lock_state == TPIO_OPEN))
    else $error("change-enable disagrees with window");
  window_count_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    window
    |-> unlock_cnt != 3'h0 && unlock_cnt <= UNLOCK_CYCLES)
    else $error("window counter out of range");
  window_close_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    ce && window && !ov_wr && unlock_cnt == 3'h1
    |=> lock_state == TPIO_IDLE)
    else $error("unlock window outlived its cycles");
  window_tick_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    ce && window && !ov_wr && unlock_cnt > 3'h1
    |=> lock_state == TPIO_OPEN && unlock_cnt == $past(unlock_cnt) - 3'h1)
    else $error("unlock window count skipped");
  commit_apply_a: assert property (@(posedge clk) disable iff (rst)  // [RULE4]
    commit_wr
    |=> force_high_enable == $past(wbyte[BIT_FORCE_HI]) && !override_change_enable)
    else $error("window write not applied");
  stray_write_a: assert property (@(posedge clk) disable iff (rst)  // [RULE2]
    ov_wr && !window
    |=> $stable(force_high_enable))
    else $error("force-high changed by plain write");
  unlock_reject_a: assert property (@(posedge clk) disable iff (rst)  // [RULE3]
    ov_wr && !window && wbyte != UNLOCK_VALUE
    |=> lock_state == TPIO_IDLE)
    else $error("window opened by wrong value");
  ovr_write_a: assert property (@(posedge clk) disable iff (rst)  // [RULE11]
    ov_wr
    |=> tx_drive_override == $past(wbyte[BIT_TX_OVR]))
    else $error("transmit override write lost");

  // ==========================================================
  // Checks: pin drive
  tx_low_a: assert property (@(posedge clk) disable iff (rst)  // [RULE7] [RULE11]
    ce && sb_tx_en && !serial_bus_transmit
    |=> pb_pins.oe[3] && !pb_pins.o[3] && !pb_pins.pu[3])
    else $error("transmit low not driven low");
  tx_pullup_a: assert property (@(posedge clk) disable iff (rst)  // [RULE7]
    ce && sb_tx_en && tx_drive_override && serial_bus_transmit
    |=> pb_pins.pu[3] == $past(port_b_output[TX_PIN] & ~pullup_off))
    else $error("transmit high pull-up wrong");
  pin_release_a: assert property (@(posedge clk) disable iff (rst)  // [RULE10]
    ce && !force_high_enable
    |=> pb_pins.oe[0] == $past(port_b_direction[0]) && pb_pins.o[0] == $past(port_b_output[0]))
    else $error("pin zero still forced");
  port_b_plain_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    ce
    |=> {pb_pins.oe[7:4], pb_pins.oe[2:1], pb_pins.o[7:4], pb_pins.o[2:1]} == $past({port_b_direction[7:4], port_b_direction[2:1], port_b_output[7:4], port_b_output[2:1]}))
    else $error("port B drive differs from registers");
  pullup_rule_a: assert property (@(posedge clk) disable iff (rst)  // [RULE1] [RULE12]
    ce
    |=> pb_pins.pu[7:4] == $past(~port_b_direction[7:4] & port_b_output[7:4] & {4{~pullup_off}}))
    else $error("port B pull-up wrong");
  port_a_plain_a: assert property (@(posedge clk) disable iff (rst)  // [RULE12]
    ce
    |=> pa_pins.oe == {6'h0, $past(port_a_direction)} && pa_pins.o == {6'h0, $past(port_a_output)})
    else $error("port A drive differs from registers");
  port_a_pullup_a: assert property (@(posedge clk) disable iff (rst)  // [RULE1] [RULE12]
    ce
    |=> pa_pins.pu == {6'h0, $past(~port_a_direction & port_a_output & {2{~pullup_off}})})
    else $error("port A pull-up wrong");
  freeze_a: assert property (@(posedge clk) disable iff (rst)
    !ce
    |=> $stable(pb_pins) && $stable(pa_pins) && $stable(core_control) && $stable(force_high_enable))
    else $error("state moved while clock enable low");
  force_pull_a: assert property (@(posedge clk) disable iff (rst)  // [RULE9]
    ce && force_high_enable
    |=> !pb_pins.pu[0])
    else $error("pull-up on forced pin zero");
  pa_pin_read_a: assert property (@(posedge clk) disable iff (rst)  // [RULE13]
    ack_o && $past(req && hit_pa_p && !we_i)
    |-> dat_o[7:0] == {6'h0, $past(pa_s2)})
    else $error("port A level read wrong");
endmodule
`default_nettype wire

//--- test/tpio_pin_model.sv
// Board-side pin model: resolves each pin from block drive, pull-up and external source.
`timescale 1ns/1ns
`default_nettype none
module tpio_pin_model (
  input  wire tpio_pkg::tpio_pins_t pins, // Drive from the block
  input  wire logic [7:0]           ext,  // External board level on undriven pins
  output logic      [7:0]           lvl   // Resolved pin level
);
  import tpio_pkg::*;
  // Pull-up wins over the board source, which is weak
  assign lvl = (pins.oe & pins.o) | (~pins.oe & pins.pu) | (~pins.oe & ~pins.pu & ext);
endmodule
`default_nettype wire

//--- test/tpio_top_tb.sv
// Self-checking bench for the two-port I/O block.
`timescale 1ns/1ns
`default_nettype none
module tpio_top_tb;
  import tpio_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_en = 1'b0, tx = 1'b0, po;
  logic        ack_o, err_o, cko, vts;
  logic [3:0]  sel = 4'h1;
  logic [9:0]  adr = 10'h000;
  logic [31:0] wdat = 32'h0, dat_o;
  logic [7:0]  pa_l, pb_l, ext_a = 8'h00, ext_b = 8'h00, d, o, r;
  logic [33:0] nt;
  logic [33:0] notes[$];
  tpio_pins_t  pa_pins, pb_pins;
  integer      bad_count = 0, cmp_count = 0, seed = 32'ha5831e1d;
  logic [7:0]  idx_tbl[6] = '{OFS_PA_DIR, OFS_PA_OUT, OFS_PB_DIR, OFS_PB_OUT, OFS_CORE_CTL, OFS_PB_OVR};
  always #20 clk = ~clk;
  tpio_top u_tpio_top (.clk(clk), .rst(rst), .ce(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .pa_i(pa_l[1:0]), .pa_pins(pa_pins),
    .pb_i(pb_l), .pb_pins(pb_pins), .sb_tx_en(tx_en), .serial_bus_transmit(tx), .clock_out_enable(cko),
    .vector_table_select(vts));
  tpio_pin_model u_tpio_pin_model (.pins(pa_pins), .ext(ext_a), .lvl(pa_l));
  tpio_pin_model u_tpio_pin_model_b (.pins(pb_pins), .ext(ext_b), .lvl(pb_l));
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Request held until ack or err is sampled; the note tells the monitor what to expect
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] dt, input logic [7:0] e, input logic er);
    int n;
    n = 0;
    notes.push_back({~w, er, 24'h0, e});
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, dt};
    do @(posedge clk); while (ack_o !== 1'b1 && err_o !== 1'b1 && ++n < 50);
    if (n >= 50) check(32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] dt);
    wb(1'b1, idx, dt, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, e, 1'b0);
  endtask
  function automatic logic [7:0] lvl(input logic [7:0] dd, input logic [7:0] oo, input logic [7:0] x, input logic p);
    lvl = (dd & oo) | (~dd & oo & {8{~p}}) | (~dd & ~(oo & {8{~p}}) & x);
  endfunction
  always @(posedge clk) begin
    if (ack_o === 1'b1 || err_o === 1'b1) begin
      nt = notes.pop_front();
      check({31'h0, err_o}, {31'h0, nt[32]});
      if (nt[33]) check(dat_o, nt[31:0]);
    end
  end
  initial begin
    #400000;
    bad_count++;
    stop_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (idx_tbl[i]) rd(idx_tbl[i], 8'h00);
    wb(1'b0, 8'h10, 8'h00, 8'h00, 1'b1);
    $display("Test reset values done");
    for (int k = 0; k < 4; k++) begin
      r = $random(seed);
      d = $random(seed);
      o = $random(seed);
      ext_a <= $random(seed);
      ext_b <= $random(seed);
      po = r[4];
      wr(OFS_CORE_CTL, r);
      foreach (idx_tbl[i]) if (i < 4) wr(idx_tbl[i], i[0] ? o : d);
      repeat (4) @(posedge clk);
      check({16'h0, pb_pins.oe, pb_pins.o & d}, {16'h0, d, o & d});
      check({16'h0, pa_pins.pu, pa_pins.o}, {16'h0, 6'h0, ~d[1:0] & o[1:0] & {2{~po}}, 6'h0, o[1:0]});
      check({24'h0, pb_pins.pu}, {24'h0, ~d & o & {8{~po}}});
      check({24'h0, pa_pins.oe}, {24'h0, 6'h0, d[1:0]});
      check({30'h0, cko, vts}, {30'h0, r[5], r[1]});
      rd(OFS_CORE_CTL, r & CORE_CTL_MASK);
      rd(OFS_PA_OUT, {6'h0, o[1:0]});
      rd(OFS_PB_PIN, lvl(d, o, ext_b, po));
      rd(OFS_PA_PIN, lvl(d, o, ext_a, po) & 8'h03);
    end
    sel <= 4'h0;
    wr(OFS_PB_OUT, ~o);
    sel <= 4'h1;
    rd(OFS_PB_OUT, o);
    $display("Test port registers done");
    wr(OFS_PB_OVR, 8'hff);
    rd(OFS_PB_OVR, 8'h08);
    wr(OFS_PB_OVR, UNLOCK_VALUE);
    wr(OFS_PB_OVR, 8'h01);
    rd(OFS_PB_OVR, 8'h01);
    check({30'h0, pb_pins.o[0], pb_pins.oe[0]}, 32'h3);
    wr(OFS_PB_OVR, UNLOCK_VALUE);
    repeat (6) @(posedge clk);
    wr(OFS_PB_OVR, 8'h00);
    rd(OFS_PB_OVR, 8'h01);
    wr(OFS_PB_OVR, UNLOCK_VALUE);
    wr(OFS_PB_OVR, 8'h00);
    rd(OFS_PB_OVR, 8'h00);
    check({31'h0, pb_pins.oe[0]}, {31'h0, d[0]});
    $display("Test override done");
    wr(OFS_PB_DIR, 8'h00);
    for (int k = 0; k < 16; k++) begin
      o[3] = k[1];
      wr(OFS_PB_OUT, o);
      wr(OFS_PB_OVR, {4'h0, k[0], 3'h0});
      tx_en <= k[3];
      tx <= k[2];
      repeat (3) @(posedge clk);
      r[2] = k[3] & (~k[0] | ~k[2]);
      r[1] = r[2] & ~k[0] & k[2];
      r[0] = ~r[2] & k[1] & ~po;
      check({29'h0, pb_pins.oe[3], pb_pins.o[3] & pb_pins.oe[3], pb_pins.pu[3]}, {29'h0, r[2:0]});
    end
    $display("Test transmit drive done");
    ce <= 1'b0;
    tx <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, pb_pins.oe[3]}, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, pb_pins.oe[3]}, 32'h1);
    tx_en <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_PB_OVR, 8'h00);
    rd(OFS_CORE_CTL, 8'h00);
    check({8'h0, pb_pins.oe, pb_pins.o, pb_pins.pu}, 32'h0);
    $display("Test freeze and reset done");
    stop_test();
  end
endmodule
`default_nettype wire
